// [hdl/pcpmap_consts.svh]
// constants for the priority-code remap block: offsets, field width, code count, resets
// assumes it is included by bare name from the design files
`ifndef PCPMAP_CONSTS_SVH
`define PCPMAP_CONSTS_SVH
`define PCPMAP_OFS_LOW 8'h80
`define PCPMAP_OFS_HIGH 8'h81
`define PCPMAP_RST_LOW 8'h50
`define PCPMAP_RST_HIGH 8'hfa
`define PCPMAP_FIELD_W 2
`define PCPMAP_CODES 8
`endif

// [hdl/pcpmap_pkg.sv]
// types shared by the priority-code remap block
// assumes the consts header defines the field width
`include "pcpmap_consts.svh"
package pcpmap_pkg;
    typedef logic [`PCPMAP_FIELD_W-1:0] pcpmap_prio_t; // internal frame priority
    typedef logic [2:0] pcpmap_code_t; // 802.1p priority code
    typedef enum logic [1:0] {
        PCPMAP_IDLE = 2'h0, // no lookup pending
        PCPMAP_BUSY = 2'h1 // result valid this cycle
    } pcpmap_state_t;
endpackage : pcpmap_pkg

// [hdl/pcpmap_lookup_if.sv]
// carrier between the top and the lookup stage
// assumes one clock, ref_clk
`timescale 1ns/1ps
interface pcpmap_lookup_if;
    import pcpmap_pkg::*;
    logic [15:0] table_bits; // all eight fields, code n at bits 2n+1:2n
    logic req; // classify request
    pcpmap_code_t code; // code to classify
    logic vld; // result valid
    pcpmap_prio_t prio; // mapped priority
    modport top (output table_bits, req, code, input vld, prio);
    modport lkp (input table_bits, req, code, output vld, prio);
endinterface : pcpmap_lookup_if

// [hdl/pcpmap_lookup.sv]
// lookup stage: picks the field for a code from the eight-entry table
// assumes table bits are stable registers in the same clock domain
`timescale 1ns/1ps
`include "pcpmap_consts.svh"
module pcpmap_lookup
    import pcpmap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    pcpmap_lookup_if.lkp lk
);
    pcpmap_prio_t field_w [`PCPMAP_CODES]; // fields split per code
    pcpmap_prio_t sel_w; // field picked by the code
    pcpmap_state_t state_q;
    pcpmap_prio_t prio_q;
    // one slice per code
    for (genvar g = 0; g < `PCPMAP_CODES; g++) begin : g_field
        assign field_w[g] = lk.table_bits[2*g+1:2*g];
    end
    assign sel_w = field_w[lk.code];
    // register the result; table read live so a write counts on the next request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= PCPMAP_IDLE;
            prio_q <= 2'h0;
        end else begin
            state_q <= lk.req ? PCPMAP_BUSY : PCPMAP_IDLE;
            if (lk.req) begin
                prio_q <= sel_w;
            end
        end
    end
    assign lk.vld = (state_q == PCPMAP_BUSY);
    assign lk.prio = prio_q;
endmodule : pcpmap_lookup

// [hdl/pcp_priority_remap.sv]
// top of the 802.1p priority remap: two byte mapping registers, a registered
// read port and a two-stage classify pipeline (lookup flop, then output flop)
// assumes a byte-wide management port with one write or read strobe per cycle,
// and a classify requester that needs no back-pressure: one request per cycle
// assumes every input is synchronous to ref_clk and sys_rst is synchronous
// assumes nothing downstream needs the result before the second edge
//
// Contract
// - code zero uses low register bits 1:0
// - code one uses low register bits 3:2
// - code two uses low register bits 5:4
// - code three uses low register bits 7:6
// - code seven uses high register bits 7:6
// - codes six..four use high bits 5:0
`timescale 1ns/1ps
`include "pcpmap_consts.svh"
module pcp_priority_remap
    import pcpmap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic cls_req,
    input wire logic [2:0] cls_code,
    output logic cls_vld,
    output logic [1:0] cls_prio
);
    // carrier to the lookup stage; the table and request travel together
    pcpmap_lookup_if lk ();

    // mapping storage: one byte per register, four 2-bit fields each
    logic [7:0] low_q; // pcp_map_low_codes, codes 3..0
    logic [7:0] high_q; // pcp_map_high_codes, codes 7..4

    // read port state
    logic [7:0] rdata_q; // last read value, held until the next read
    logic rvalid_q; // one-cycle echo of the read strobe

    // classify output stage
    logic cls_vld_q; // result valid, two cycles after the request
    pcpmap_prio_t cls_prio_q; // mapped priority, zero while not valid

    // address decode as named wires
    wire sel_low_w = (reg_addr == `PCPMAP_OFS_LOW); // low codes register hit
    wire sel_high_w = (reg_addr == `PCPMAP_OFS_HIGH); // high codes register hit
    wire sel_none_w = !sel_low_w && !sel_high_w; // unmapped offset
    // unmapped offsets read zero so software can probe the map safely
    wire [7:0] rd_mux_w = sel_low_w ? low_q : (sel_high_w ? high_q : 8'h00);

    // writes to unmapped offsets fall through both branches and are dropped
    // field write; a register write lands before any later classify request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            low_q <= `PCPMAP_RST_LOW;
            high_q <= `PCPMAP_RST_HIGH;
        end else if (reg_wr) begin
            if (sel_low_w) begin
                low_q <= reg_wdata;
            end else if (sel_high_w) begin
                high_q <= reg_wdata;
            end
        end
    end

    // read data; unmapped offsets read zero
    // a read in the same cycle as a write to the same byte returns the old value
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rd_mux_w;
            end
        end
    end

    // the table is handed over live: a write is seen by the next request
    assign lk.table_bits = {high_q, low_q}; // code n at bits 2n+1:2n
    assign lk.req = cls_req; // one request per cycle, no stall
    assign lk.code = cls_code; // code qualified by the request
    // lookup stage: registers the picked field one cycle after the request
    pcpmap_lookup pcpmap_lookup_inst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .lk(lk)
    );

    // output flops: costs one more cycle, but keeps outputs glitch free
    // cls_prio is forced to zero between results so idle cycles carry no stale class
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cls_vld_q <= 1'b0;
            cls_prio_q <= 2'h0;
        end else begin
            cls_vld_q <= lk.vld;
            cls_prio_q <= lk.vld ? lk.prio : 2'h0;
        end
    end
    // every top-level output comes straight from a flop
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign cls_vld = cls_vld_q;
    assign cls_prio = cls_prio_q;

    // checks on the classify pipeline: a request at edge c0 shows at c2,
    // and the field is the one the table held when the request was taken
    // expected priority, taken from the table at request time
    logic [15:0] tbl_w;
    assign tbl_w = {high_q, low_q};
    AST_CODE0: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h0 |-> ##2 cls_vld && cls_prio == $past(low_q[1:0], 2))
        else $error("code zero mapped wrong");
    AST_CODE1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h1 |-> ##2 cls_prio == $past(low_q[3:2], 2))
        else $error("code one mapped wrong");
    AST_CODE2: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h2 |-> ##2 cls_prio == $past(low_q[5:4], 2))
        else $error("code two mapped wrong");
    AST_CODE3: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h3 |-> ##2 cls_prio == $past(low_q[7:6], 2))
        else $error("code three mapped wrong");
    AST_CODE7: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h7 |-> ##2 cls_prio == $past(high_q[7:6], 2))
        else $error("code seven mapped wrong");
    AST_CODE654: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code[2] && cls_code != 3'h7 |-> ##2
        cls_prio == $past(tbl_w[{cls_code, 1'b0} +: 2], 2))
        else $error("codes four to six mapped wrong");
    AST_RESET_VAL: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> low_q == `PCPMAP_RST_LOW && high_q == `PCPMAP_RST_HIGH)
        else $error("mapping reset values wrong");
    AST_WR_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel_low_w ##1 reg_rd && !reg_wr && sel_low_w |-> ##1
        reg_rvalid && reg_rdata == $past(reg_wdata, 2))
        else $error("low register readback wrong");
    AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && !sel_low_w && !sel_high_w |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    COV_WR_HIGH: cover property (@(posedge ref_clk) reg_wr && sel_high_w);
    COV_CLS7: cover property (@(posedge ref_clk) cls_req && cls_code == 3'h7 ##2 cls_vld);
    COV_BACK: cover property (@(posedge ref_clk) cls_req [*3]);
    COV_WR_RD_LOW: cover property (@(posedge ref_clk)
        reg_wr && sel_low_w ##1 reg_rd && sel_low_w);
    COV_RD_NONE: cover property (@(posedge ref_clk) reg_rd && sel_none_w ##1 reg_rvalid);

    // field-by-field checks of the high register
    // code four sits in bits 1:0; no computed index, so a slicing slip shows
    AST_CODE4: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h4 |-> ##2 cls_prio == $past(high_q[1:0], 2))
        else $error("code four mapped wrong");

    // code five sits in bits 3:2 of the high register
    AST_CODE5: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h5 |-> ##2 cls_prio == $past(high_q[3:2], 2))
        else $error("code five mapped wrong");

    // code six sits in bits 5:4 of the high register
    AST_CODE6: assert property (@(posedge ref_clk) disable iff (sys_rst)
        cls_req && cls_code == 3'h6 |-> ##2 cls_prio == $past(high_q[5:4], 2))
        else $error("code six mapped wrong");

    // no request, no result two cycles on
    AST_NO_REQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !cls_req |-> ##2 !cls_vld)
        else $error("result valid without a request");

    // the priority reads zero between results
    AST_IDLE_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !cls_vld |-> cls_prio == 2'h0)
        else $error("priority not zero while idle");

    // a write to the low register lands at the next edge
    AST_WR_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel_low_w |=> low_q == $past(reg_wdata))
        else $error("low register write lost");

    // a write to the high register lands at the next edge
    AST_WR_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel_high_w |=> high_q == $past(reg_wdata))
        else $error("high register write lost");

    // a write to any other offset leaves both mapping bytes alone
    AST_OTHER_WR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && sel_none_w |=> $stable(low_q) && $stable(high_q))
        else $error("unmapped write changed a mapping byte");

    // a read of the low register returns the byte held when it was taken
    AST_RD_LOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && sel_low_w |=> reg_rdata == $past(low_q))
        else $error("low register read wrong");

    // a read of the high register returns the byte held when it was taken
    AST_RD_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd && sel_high_w |=> reg_rdata == $past(high_q))
        else $error("high register read wrong");

    // every read is answered by a valid strobe one cycle later
    AST_RVALID: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");

    // without a read the strobe stays low and the read data holds
    // software may sample the data late, so it must not drift
    AST_NO_RD: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
        else $error("read port moved without a read");

    // all outputs sit at their idle values right after a reset edge
    // this one keeps no disable so it also watches the mid-run reset
    AST_RESET_OUT: assert property (@(posedge ref_clk)
        $past(sys_rst) |-> !reg_rvalid && !cls_vld &&
        reg_rdata == 8'h00 && cls_prio == 2'h0)
        else $error("outputs not idle after reset");

endmodule : pcp_priority_remap

// [sim/pcp_priority_remap_bench.sv]
// bench for the 802.1p remap: register reads/writes, pipelined lookups, queue model
// assumes the hdl files compile first; outputs settle before each falling edge
`timescale 1ns/1ps
module pcp_priority_remap_bench;
    import pcpmap_pkg::*;
    logic ref_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, cls_req, cls_vld;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] cls_code;
    logic [1:0] cls_prio;
    int fails = 0, n_checks = 0, cyc = 0;
    int mdl[2]; // model of low and high mapping bytes
    int expq[$]; // expected priorities, oldest first
    logic [31:0] seed = 32'h6ea3;
    logic [7:0] ua; // unmapped address
    pcp_priority_remap pcp_priority_remap_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cls_req(cls_req),
        .cls_code(cls_code), .cls_vld(cls_vld), .cls_prio(cls_prio));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_prio(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_prio
    // strobes stay up between tasks so back-to-back cycles never glitch low
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        reg_rd = 1'b0;
        cls_req = 1'b0;
        @(negedge ref_clk);
        if (a == 8'h80) mdl[0] = d;
        else if (a == 8'h81) mdl[1] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input int exp);
        reg_addr = a;
        reg_rd = 1'b1;
        reg_wr = 1'b0;
        cls_req = 1'b0;
        @(negedge ref_clk);
        chk_reg({7'h0, reg_rvalid}, 8'h01);
        chk_reg(reg_rdata, 8'(exp));
    endtask : rd
    task automatic cls(input int c);
        cls_code = 3'(c);
        cls_req = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        expq.push_back((mdl[c / 4] >> (2 * (c % 4))) & 3);
        @(negedge ref_clk);
    endtask : cls
    // result monitor: every valid pops the model, idle output must read zero
    always @(negedge ref_clk) begin
        if (!sys_rst && cls_vld === 1'b1 && expq.size() > 0)
            chk_prio(cls_prio, 2'(expq.pop_front()));
        else if (!sys_rst) begin
            chk_prio(cls_prio, 2'h0);
            chk_prio({1'b0, cls_vld}, 2'h0);
        end
    end
    // hang guard: run needs fewer than 160 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cls_req = 1'b0;
        cls_code = 3'h0;
        for (int t = 0; t < 8; t++) begin
            if (t == 0 || t == 5) begin // power-up and mid-run reset
                sys_rst = 1'b1;
                repeat (5) @(negedge ref_clk);
                sys_rst = 1'b0;
                mdl[0] = {2'h1, 2'h1, 2'h0, 2'h0};
                mdl[1] = {2'h3, 2'h3, 2'h2, 2'h2};
            end else begin
                seed = lfsr(seed);
                ua = (seed[15:9] == 7'h40) ? 8'h7f : seed[15:8];
                wr(8'h80, seed[7:0]);
                rd(8'h80, mdl[0]);
                wr(ua, ~seed[7:0]);
                seed = lfsr(seed);
                wr(8'h81, seed[7:0]);
            end
            for (int c = 0; c < 8; c++) cls((c * 5 + t) % 8);
            rd(8'h80, mdl[0]);
            rd(8'h81, mdl[1]);
            rd(8'h82, 0);
            reg_rd = 1'b0;
            repeat (4) @(negedge ref_clk);
            chk_reg(8'(expq.size()), 8'h00);
            $display("test %0d done", t);
        end
        close_out();
    end
endmodule : pcp_priority_remap_bench
